// ### rsebs_reset_ctrl.sv
// Purpose: Combines reset sources, drives reset entry effects and picks the start vector on exit
// Assumes: Sources are asynchronous levels; signature byte is stable from flash while in reset
// Notes: The pin request is ignored while this block sinks the pin, so its own drive never reads back as a source
`default_nettype none
module rsebs_reset_ctrl
  import rsebs_pkg::*;
#(
  parameter logic [15:0] BOOT_VECTOR = BOOT_VECTOR_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [NUM_SRC-1:0] resetSrc,
  input wire logic externalResetPinIn,
  input wire logic [7:0] bootSignature,
  output logic externalResetPinOut,
  output logic externalResetPinOe,
  output logic sysResetActive,
  output rsebs_core_t coreCtrl,
  output rsebs_periph_t periphCtrl
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: first stage read only by second
  logic [NUM_SRC-1:0] srcMeta_q, srcSync_q;
  logic pinMeta_q, pinSync_q;
  logic oeDly1_q, oeDly2_q;
  logic pinReq;

  // Sources and the inverted pin each pass two flip-flops before any logic reads them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srcMeta_q <= '0;
      srcSync_q <= '0;
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
      oeDly1_q <= 1'b1;
      oeDly2_q <= 1'b1;
    end else begin
      srcMeta_q <= resetSrc;
      srcSync_q <= srcMeta_q;
      pinMeta_q <= ~externalResetPinIn;
      pinSync_q <= pinMeta_q;
      oeDly1_q <= externalResetPinOe;
      oeDly2_q <= oeDly1_q;
    end
  end

  // Our own sink reads back low on the pin; it is ignored while driving and for the
  // two synchroniser cycles after, otherwise a power-on reset would hold itself forever
  assign pinReq = pinSync_q & ~(externalResetPinOe | oeDly1_q | oeDly2_q);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  rsebs_state_t state_q, state_d;
  logic [3:0] holdCnt_q, holdCnt_d;
  logic pinLow_q, pinLow_d;
  logic [15:0] vector_q, vector_d;
  logic anySrc;

  assign anySrc = (|srcSync_q) | pinReq;

  always_comb begin
    state_d = state_q;
    holdCnt_d = holdCnt_q;
    pinLow_d = pinLow_q;
    vector_d = vector_q;
    case (state_q)
      RSEBS_RUN: begin
        if (anySrc) begin
          state_d = RSEBS_HOLD;
          holdCnt_d = '0;
          pinLow_d = srcSync_q[SRC_POR] | srcSync_q[SRC_SUPPLY];
        end
      end
      RSEBS_HOLD: begin
        if (srcSync_q[SRC_POR] | srcSync_q[SRC_SUPPLY]) begin
          pinLow_d = 1'b1;
        end
        if (anySrc) begin
          holdCnt_d = '0;
        end else if (holdCnt_q < HOLD_CYCLES) begin
          holdCnt_d = holdCnt_q + 4'h1;
        end else begin
          state_d = RSEBS_EXIT;
          vector_d = (bootSignature == BOOT_SIG_PRESENT) ? BOOT_VECTOR : APP_VECTOR;
        end
      end
      RSEBS_EXIT: begin
        pinLow_d = 1'b0;
        state_d = anySrc ? RSEBS_HOLD : RSEBS_RUN;
        holdCnt_d = '0;
      end
      default: begin
        state_d = RSEBS_HOLD;
        holdCnt_d = '0;
      end
    endcase
  end

  // Power-on reset puts the sequencer in hold, so everything is initialised
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= RSEBS_HOLD;
      holdCnt_q <= '0;
      pinLow_q <= 1'b1;
      vector_q <= APP_VECTOR;
    end else begin
      state_q <= state_d;
      holdCnt_q <= holdCnt_d;
      pinLow_q <= pinLow_d;
      vector_q <= vector_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; computed from next state so they align with it
  logic inReset_d;
  rsebs_core_t core_d;
  rsebs_periph_t periph_d;
  assign inReset_d = (state_d != RSEBS_RUN);

  always_comb begin
    core_d.coreHalt = inReset_d;
    core_d.regInit = (state_d == RSEBS_HOLD);
    core_d.pcClear = inReset_d;
    core_d.clkSel = CLK_SEL_INTOSC;
    core_d.startVector = vector_d;
    periph_d.portLatchSet = inReset_d & PORT_LATCH_RESET;
    periph_d.portOpenDrain = inReset_d;
    periph_d.weakPullupEn = 1'b1;
    periph_d.irqTimerDisable = inReset_d;
    periph_d.ramWriteBlock = inReset_d;
    periph_d.wdogEnable = 1'b1;
    periph_d.wdogTimeoutDefault = inReset_d;
    periph_d.wdogTimeout = WDOG_TIMEOUT_MAX;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sysResetActive <= 1'b1;
      coreCtrl <= '{coreHalt: 1'b1, regInit: 1'b1, pcClear: 1'b1, startVector: APP_VECTOR, clkSel: CLK_SEL_INTOSC};
      periphCtrl <= '{portLatchSet: 1'b1, portOpenDrain: 1'b1, weakPullupEn: 1'b1, irqTimerDisable: 1'b1,
                      ramWriteBlock: 1'b1, wdogEnable: 1'b1, wdogTimeoutDefault: 1'b1,
                      wdogTimeout: WDOG_TIMEOUT_MAX};
      externalResetPinOut <= 1'b0;
      externalResetPinOe <= 1'b1;
    end else begin
      sysResetActive <= inReset_d;
      coreCtrl <= core_d;
      periphCtrl <= periph_d;
      externalResetPinOut <= 1'b0;
      externalResetPinOe <= pinLow_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_HALT: assert property (@(posedge clk) disable iff (!resetn)
    sysResetActive |-> coreCtrl.coreHalt) else $error("Core not halted in reset");
  AST_PORTS: assert property (@(posedge clk) disable iff (!resetn)
    sysResetActive |-> (periphCtrl.portLatchSet && periphCtrl.portOpenDrain)) else $error("Ports not forced");
  AST_PULLUP: assert property (@(posedge clk) disable iff (!resetn)
    periphCtrl.weakPullupEn) else $error("Pull-ups disabled");
  AST_IRQ: assert property (@(posedge clk) disable iff (!resetn)
    sysResetActive |-> periphCtrl.irqTimerDisable) else $error("Interrupts not disabled");
  AST_PINREL: assert property (@(posedge clk) disable iff (!resetn)
    $fell(sysResetActive) |-> !externalResetPinOe) else $error("Pin held low after exit");
  AST_POR_PIN: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == RSEBS_HOLD && srcSync_q[SRC_POR]) |=> externalResetPinOe) else $error("Pin not driven");
  AST_WDOG_PIN: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == RSEBS_RUN && srcSync_q == (NUM_SRC'(1) << SRC_WDOG)) |=> !externalResetPinOe)
    else $error("Watchdog reset drove pin");
  AST_ENTER: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == RSEBS_RUN && anySrc) |=> sysResetActive) else $error("Reset not entered");
  AST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    $rose(sysResetActive) |-> sysResetActive[*3]) else $error("Reset too short");
  AST_BOOT: assert property (@(posedge clk) disable iff (!resetn)
    (state_d == RSEBS_EXIT && state_q == RSEBS_HOLD && bootSignature == BOOT_SIG_PRESENT)
    |=> coreCtrl.startVector == BOOT_VECTOR) else $error("Wrong boot vector");
  AST_APP: assert property (@(posedge clk) disable iff (!resetn)
    (state_d == RSEBS_EXIT && state_q == RSEBS_HOLD && bootSignature != BOOT_SIG_PRESENT)
    |=> coreCtrl.startVector == APP_VECTOR) else $error("Wrong app vector");
  AST_WDOG: assert property (@(posedge clk) disable iff (!resetn)
    $fell(sysResetActive) |-> (periphCtrl.wdogEnable && periphCtrl.wdogTimeout == WDOG_TIMEOUT_MAX))
    else $error("Watchdog not running at exit");

endmodule : rsebs_reset_ctrl
`default_nettype wire

// ### rsebs_pkg.sv
// Purpose: Shared constants and types for the reset entry/exit and boot select block
// Assumes: 50 MHz system clock, one clock domain
// Notes: Source vector bit positions are fixed here and used by the core module
`default_nettype none
package rsebs_pkg;
  // Reset source bit positions
  localparam int SRC_POR = 0;
  localparam int SRC_PIN = 1;
  localparam int SRC_CMP = 2;
  localparam int SRC_SW = 3;
  localparam int SRC_SUPPLY = 4;
  localparam int SRC_WDOG = 5;
  localparam int SRC_MISCLK = 6;
  localparam int SRC_FLASH = 7;
  localparam int SRC_USB = 8;
  localparam int NUM_SRC = 9;
  // Boot selection
  localparam logic [7:0] BOOT_SIG_PRESENT = 8'hA5;
  localparam logic [15:0] APP_VECTOR = 16'h0000;
  localparam logic [15:0] BOOT_VECTOR_DEF = 16'h9800; // Plain default, a parameter of the top
  // Hold counter limit; the internal reset lasts at least this plus two cycles
  localparam logic [3:0] HOLD_CYCLES = 4'h2;
  localparam logic [2:0] WDOG_TIMEOUT_MAX = 3'h7;
  localparam logic [1:0] CLK_SEL_INTOSC = 2'h0;
  localparam logic PORT_LATCH_RESET = 1'b1;

  // Sequencer states
  typedef enum logic [2:0] {
    RSEBS_RUN = 3'b001,
    RSEBS_HOLD = 3'b010,
    RSEBS_EXIT = 3'b100
  } rsebs_state_t;

  // Controls to the core
  typedef struct packed {
    logic coreHalt;
    logic regInit;
    logic pcClear;
    logic [15:0] startVector;
    logic [1:0] clkSel;
  } rsebs_core_t;

  // Controls to the port logic, watchdog and peripherals
  typedef struct packed {
    logic portLatchSet;
    logic portOpenDrain;
    logic weakPullupEn;
    logic irqTimerDisable;
    logic ramWriteBlock;
    logic wdogEnable;
    logic wdogTimeoutDefault;
    logic [2:0] wdogTimeout;
  } rsebs_periph_t;
endpackage : rsebs_pkg
`default_nettype wire

// ### rsebs_partner.sv
// Purpose: Far-side model of the reset sources and the reset pin wire
// Assumes: The reset pin has an external pull-up
// Notes: Sources are plain levels chosen by the bench
`default_nettype none
module rsebs_partner
  import rsebs_pkg::*;
(
  input wire logic [NUM_SRC-1:0] srcReq,
  input wire logic pinPullLow,
  input wire logic pinOe,
  output logic [NUM_SRC-1:0] resetSrc,
  output logic externalResetPinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  assign resetSrc = srcReq;
  // Wired pin: the pull-up wins unless a party sinks it
  assign externalResetPinIn = ~(pinOe | pinPullLow);
endmodule : rsebs_partner
`default_nettype wire

// ### rsebs_reset_ctrl_tb.sv
// Purpose: Self-checking bench for the reset controller
// Assumes: 50 MHz clock, inputs driven on the falling edge
// Notes: Each source is pulsed once in turn, the signature alternating; the watchdog source again at the end
`default_nettype none
module rsebs_reset_ctrl_tb import rsebs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BOOT_VEC = 16'h9A00;
  logic clk, resetn, pinPullLow, pinIn, pinOut, pinOe, active;
  logic [NUM_SRC-1:0] srcReq, resetSrc;
  logic [7:0] sig;
  rsebs_core_t core;
  rsebs_periph_t per;
  int n_mismatch = 0;
  int total_checks = 0;
  ////////////////////////////////////////////////////////////
  rsebs_reset_ctrl #(.BOOT_VECTOR(BOOT_VEC)) u_dut (.clk(clk), .resetn(resetn), .resetSrc(resetSrc),
    .externalResetPinIn(pinIn), .bootSignature(sig), .externalResetPinOut(pinOut),
    .externalResetPinOe(pinOe), .sysResetActive(active), .coreCtrl(core), .periphCtrl(per));
  rsebs_partner u_far (.srcReq(srcReq), .pinPullLow(pinPullLow), .pinOe(pinOe),
    .resetSrc(resetSrc), .externalResetPinIn(pinIn));
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  // Bounded wait; a hang ends the run as a failure
  task automatic waitActive(input logic lvl);
    int k = 0;
    while (active !== lvl && k < 40) begin
      @(negedge clk);
      k++;
    end
    if (active !== lvl) begin
      n_mismatch++;
      $display("mismatch sysResetActive expected %b seen %b", lvl, active);
      wrap_up();
    end
  endtask : waitActive
  // Entry effects while the reset state stands
  task automatic chkEntry(input logic expOe);
    chk("entry", 16'h01FF, 16'({core.coreHalt, core.regInit, core.pcClear, per.portLatchSet,
      per.portOpenDrain, per.weakPullupEn, per.irqTimerDisable, per.ramWriteBlock,
      per.wdogTimeoutDefault}));
    chk("pinOe", 16'(expOe), 16'(pinOe));
    chk("pinOut", 16'h0000, 16'(pinOut));
  endtask : chkEntry
  // Exit state once the reset state has been left
  task automatic chkExit(input logic [15:0] expVec);
    chk("startVector", expVec, core.startVector);
    chk("clkSel", 16'(CLK_SEL_INTOSC), 16'(core.clkSel));
    chk("haltOe", 16'h0000, 16'({core.coreHalt, pinOe}));
    chk("wdog", 16'({1'b1, WDOG_TIMEOUT_MAX}), 16'({per.wdogEnable, per.wdogTimeout}));
    chk("pullup", 16'h0001, 16'(per.weakPullupEn));
    chk("released", 16'h0000, 16'({core.regInit, core.pcClear, per.portLatchSet, per.portOpenDrain,
      per.irqTimerDisable, per.ramWriteBlock, per.wdogTimeoutDefault}));
  endtask : chkExit
  ////////////////////////////////////////////////////////////
  // One source pulsed; odd sources see a wrong signature
  task automatic srcScenario(input int i);
    logic [15:0] vec;
    sig = i[0] ? 8'hA4 : BOOT_SIG_PRESENT;
    vec = i[0] ? APP_VECTOR : BOOT_VEC;
    srcReq[i] = 1'b1;
    waitActive(1'b1);
    @(negedge clk);
    chkEntry(i == SRC_POR || i == SRC_SUPPLY);
    srcReq[i] = 1'b0;
    @(negedge clk);
    chk("haltInHold", 16'h0001, 16'(core.coreHalt));
    waitActive(1'b0);
    chkExit(vec);
  endtask : srcScenario
  // Reset requested by sinking the external pin
  task automatic pinScenario();
    sig = BOOT_SIG_PRESENT;
    pinPullLow = 1'b1;
    waitActive(1'b1);
    @(negedge clk);
    chkEntry(1'b0);
    pinPullLow = 1'b0;
    waitActive(1'b0);
    chkExit(BOOT_VEC);
  endtask : pinScenario
  ////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    srcReq = '0;
    pinPullLow = 1'b0;
    sig = BOOT_SIG_PRESENT;
    repeat (6) @(negedge clk);
    chkEntry(1'b1);
    resetn = 1'b1;
    waitActive(1'b0);
    chkExit(BOOT_VEC);
    for (int i = 0; i < NUM_SRC; i++) begin
      srcScenario(i);
    end
    pinScenario();
    // Power-on reset arriving during a watchdog reset must still sink the pin
    srcReq[SRC_WDOG] = 1'b1;
    waitActive(1'b1);
    srcReq[SRC_WDOG] = 1'b0;
    resetn = 1'b0;
    @(negedge clk);
    chkEntry(1'b1);
    resetn = 1'b1;
    waitActive(1'b0);
    chkExit(BOOT_VEC);
    wrap_up();
  end
endmodule : rsebs_reset_ctrl_tb
`default_nettype wire
